// ### hdl/ussu_pkg.sv
// Shared constants and types for the universal serial shift unit
package ussu_pkg;

  // System clock and start detector timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SDA_DELAY_NS = 50;
  localparam int SDA_DELAY_CYC = (SDA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int SYNC_STAGES = 2;

  // Reset values and counter landmarks
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'hf;
  localparam logic [3:0] CNT_ACK_PRESET = 4'he;

  // Wire mode selection (two mode bits)
  typedef enum logic [1:0] {
    WM_OFF,
    WM_THREE,
    WM_TWO,
    WM_TWO_HOLD
  } wire_mode_e;

  // Start hold sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_HOLD
  } hold_state_e;

endpackage : ussu_pkg

// ### hdl/line_if.sv
// Synchronised serial line status shared between sampler, detector and core
`timescale 1ns/1ps
`default_nettype none
interface line_if;
  logic scl_s;
  logic sda_s;
  logic sda_dly;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;

  modport sampler (output scl_s, output sda_s, output sda_dly, output scl_rise, output scl_fall);
  modport detector (input scl_s, input sda_dly, output start_evt);
  modport core (input scl_s, input sda_s, input scl_rise, input scl_fall, input start_evt);
endinterface : line_if
`default_nettype wire

// ### hdl/line_sampler.sv
// Pin synchronisers, clock edge finder and data line delay
`timescale 1ns/1ps
`default_nettype none
module line_sampler #(
  parameter int DLY = ussu_pkg::SDA_DELAY_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Raw pins
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  // Line status
  line_if.sampler ln
);
  import ussu_pkg::*;

  logic [SYNC_STAGES-1:0] scl_ff;
  logic [SYNC_STAGES-1:0] sda_ff;
  logic scl_q;
  logic [DLY-1:0] sda_pipe;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, no glitch filter on either line
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_ff <= '1;
      sda_ff <= '1;
    end else begin
      scl_ff <= {scl_ff[0], scl_pin_i};
      sda_ff <= {sda_ff[0], sda_pin_i};
    end
  end

  // Edge finder compares the synchronised clock with its value one clock earlier, so one clock per level is enough
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl_ff[1];
    end
  end

  // Data line delay ahead of the start detector
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_pipe <= '1;
    end else begin
      sda_pipe <= {sda_pipe[DLY-2:0], sda_ff[1]};
    end
  end

  assign ln.scl_s = scl_ff[1];
  assign ln.sda_s = sda_ff[1];
  assign ln.sda_dly = sda_pipe[DLY-1];
  assign ln.scl_rise = scl_ff[1] & ~scl_q;
  assign ln.scl_fall = ~scl_ff[1] & scl_q;

endmodule : line_sampler
`default_nettype wire

// ### hdl/start_detector.sv
// Start condition detector: delayed data falling while clock is high
`timescale 1ns/1ps
`default_nettype none
module start_detector (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Two-wire mode selected
  input wire logic enable_i,
  // Line status
  line_if.detector ln
);
  import ussu_pkg::*;

  logic sda_dly_q;
  logic start_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_dly_q <= 1'b1;
    end else begin
      sda_dly_q <= ln.sda_dly;
    end
  end

  // Detector is gated off outside two-wire mode
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_r <= 1'b0;
    end else begin
      start_r <= enable_i && ln.scl_s && sda_dly_q && !ln.sda_dly;
    end
  end

  assign ln.start_evt = start_r;

  a_start_gated: assert property (@(posedge clock_i) disable iff (!nrst_i)
    start_r |-> $past(enable_i) && $past(ln.scl_s))
    else $error("start event outside two-wire mode or with clock low");

endmodule : start_detector
`default_nettype wire

// ### hdl/universal_serial_shift_unit.sv
// Universal serial shift unit: shift register, edge counter, two-wire clock hold
`timescale 1ns/1ps
`default_nettype none
module universal_serial_shift_unit (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o,
  // Serial data pins
  input wire logic serial_data_in_pin_i,
  output logic data_out_pin_o,
  output logic data_out_pin_oe_n_o,
  output logic sda_pin_o,
  output logic sda_pin_oe_n_o,
  // Configuration
  input wire ussu_pkg::wire_mode_e wire_mode_i,
  input wire logic external_clock_select_i,
  input wire logic clock_edge_select_i,
  input wire logic port_clock_level_i,
  input wire logic port_clock_dir_i,
  input wire logic port_data_dir_i,
  // Clock strobes
  input wire logic software_clock_strobe_i,
  input wire logic clock_toggle_strobe_i,
  input wire logic timer_match_i,
  // Data and counter writes, flag clears
  input wire logic data_wr_i,
  input wire logic [ussu_pkg::DATA_W-1:0] data_wdata_i,
  input wire logic count_wr_i,
  input wire logic [ussu_pkg::CNT_W-1:0] count_wdata_i,
  input wire logic overflow_clear_i,
  input wire logic start_clear_i,
  // Status
  output logic [ussu_pkg::DATA_W-1:0] shift_data_o,
  output logic [ussu_pkg::CNT_W-1:0] count_o,
  output logic counter_overflow_flag_o,
  output logic start_condition_flag_o,
  output logic overflow_wake_o,
  output logic start_wake_o
);
  import ussu_pkg::*;

  line_if ln ();

  logic two_wire;
  logic three_wire;
  logic sample_edge;
  logic shift_edge;
  logic soft_clk;
  logic cnt_inc;
  logic do_shift;
  logic shift_in;
  logic ovf_evt;
  logic start_set;
  logic scl_level;
  logic hold_line;
  logic [DATA_W-1:0] sr_r;
  logic [DATA_W-1:0] sr_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic in_bit_r;
  logic ovf_flag_r;
  logic start_flag_r;
  logic toggle_r;
  hold_state_e st_r;
  hold_state_e st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling and start detection

  line_sampler u_sampler (
    .clock_i (clock_i),
    .nrst_i (nrst_i),
    .scl_pin_i (serial_clock_pin_i),
    .sda_pin_i (serial_data_in_pin_i),
    .ln (ln.sampler)
  );

  start_detector u_start (
    .clock_i (clock_i),
    .nrst_i (nrst_i),
    .enable_i (two_wire),
    .ln (ln.detector)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection

  assign two_wire = (wire_mode_i == WM_TWO) || (wire_mode_i == WM_TWO_HOLD);
  assign three_wire = (wire_mode_i == WM_THREE);
  assign sample_edge = clock_edge_select_i ? ln.scl_fall : ln.scl_rise;
  assign shift_edge = clock_edge_select_i ? ln.scl_rise : ln.scl_fall;
  assign soft_clk = clock_edge_select_i ? timer_match_i : software_clock_strobe_i;
  // Software clock drives both; external clock counts both edges but shifts on one
  assign cnt_inc = external_clock_select_i ? (ln.scl_rise | ln.scl_fall) : soft_clk;
  assign do_shift = external_clock_select_i ? shift_edge : soft_clk;
  assign shift_in = external_clock_select_i ? in_bit_r : ln.sda_s;
  assign ovf_evt = cnt_inc && !count_wr_i && (cnt_r == CNT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Shift register

  // A write in the same cycle as a shift wins, so preloading is safe
  always_comb begin
    sr_nxt = sr_r;
    if (data_wr_i) begin
      sr_nxt = data_wdata_i;
    end else if (do_shift) begin
      sr_nxt = {sr_r[DATA_W-2:0], shift_in};
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_r <= DATA_RST;
    end else begin
      sr_r <= sr_nxt;
    end
  end

  // Input bit captured on the sampling edge, used on the shifting edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_bit_r <= 1'b0;
    end else if (external_clock_select_i && sample_edge) begin
      in_bit_r <= ln.sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge counter

  always_comb begin
    cnt_nxt = cnt_r;
    if (count_wr_i) begin
      cnt_nxt = count_wdata_i;
    end else if (cnt_inc) begin
      cnt_nxt = cnt_r + CNT_ONE;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the clearing cycle wins

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_r <= 1'b1;
    end else if (overflow_clear_i) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // Outside two-wire mode the start flag marks each count step
  assign start_set = two_wire ? ln.start_evt : cnt_inc;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_flag_r <= 1'b0;
    end else if (start_set) begin
      start_flag_r <= 1'b1;
    end else if (start_clear_i) begin
      start_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock hold sequencing (two-wire slave)

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (two_wire && ln.start_evt) begin
          st_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!two_wire || !start_flag_r) begin
          st_nxt = ST_IDLE;
        end else if (!ln.scl_s) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!two_wire || !start_flag_r) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Overflow hold lasts until the overflow flag is cleared
  assign hold_line = (st_r == ST_HOLD)
    || ((wire_mode_i == WM_TWO_HOLD) && ovf_flag_r);

  ////////////////////////////////////////////////////////////////////////////
  // Software clock generation

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      toggle_r <= 1'b0;
    end else if (clock_toggle_strobe_i) begin
      toggle_r <= ~toggle_r;
    end
  end

  assign scl_level = port_clock_level_i ^ toggle_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe_n_o <= 1'b1;
    end else if (two_wire) begin
      // Open drain: only ever pulls low
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe_n_o <= !(hold_line || (port_clock_dir_i && !scl_level));
    end else begin
      serial_clock_pin_o <= scl_level;
      serial_clock_pin_oe_n_o <= !port_clock_dir_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_out_pin_o <= 1'b0;
      data_out_pin_oe_n_o <= 1'b1;
      sda_pin_o <= 1'b0;
      sda_pin_oe_n_o <= 1'b1;
    end else begin
      data_out_pin_o <= sr_r[DATA_W-1];
      data_out_pin_oe_n_o <= !(three_wire && port_data_dir_i);
      sda_pin_o <= 1'b0;
      // Msb of zero pulls data low, which is also how the ack is given
      sda_pin_oe_n_o <= !(two_wire && port_data_dir_i && !sr_r[DATA_W-1]);
    end
  end

  assign shift_data_o = sr_r;
  assign count_o = cnt_r;
  assign counter_overflow_flag_o = ovf_flag_r;
  assign start_condition_flag_o = start_flag_r;
  assign overflow_wake_o = ovf_flag_r;
  assign start_wake_o = start_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_armed_low;
    (st_r == ST_ARMED) && two_wire && start_flag_r && !ln.scl_s;
  endsequence

  sequence s_mode_kept;
    $stable(wire_mode_i);
  endsequence

  a_start_hold: assert property (s_armed_low ##1 s_mode_kept |-> ##1 !serial_clock_pin_oe_n_o)
    else $error("clock not held low after start condition");
  a_ovf_flag_set: assert property (ovf_evt |=> counter_overflow_flag_o && (count_o == CNT_RST))
    else $error("overflow did not wrap counter and set flag");
  a_ext_count_edges: assert property (
    (external_clock_select_i && ln.scl_fall && !count_wr_i) |=> count_o == $past(count_o) + CNT_ONE)
    else $error("external edge not counted");
  a_sample_rise: assert property (
    (external_clock_select_i && !clock_edge_select_i && ln.scl_rise) |=> in_bit_r == $past(ln.sda_s))
    else $error("data not sampled on rising edge");
  a_sample_fall: assert property (
    (external_clock_select_i && clock_edge_select_i && ln.scl_fall) |=> in_bit_r == $past(ln.sda_s))
    else $error("data not sampled on falling edge");
  a_shift_fall: assert property (
    (external_clock_select_i && !clock_edge_select_i && ln.scl_fall && !data_wr_i)
      |=> shift_data_o == {$past(shift_data_o[DATA_W-2:0]), $past(in_bit_r)})
    else $error("register did not shift on falling edge");
  a_write_wins: assert property (data_wr_i |=> shift_data_o == $past(data_wdata_i))
    else $error("written data lost to a shift");
  a_msb_first: assert property ($changed(sr_r) |=> data_out_pin_o == $past(sr_r[DATA_W-1]))
    else $error("data output does not follow msb");
  a_start_flag: assert property ((two_wire && ln.start_evt) |=> start_condition_flag_o [*1])
    else $error("start condition flag not set");

endmodule : universal_serial_shift_unit
`default_nettype wire

// ### dv/far_master.sv
// Behavioural far-side master that drives the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module far_master (
  // Device pin drives
  input wire logic scl_pin_i,
  input wire logic scl_oe_n_i,
  input wire logic sda_pin_i,
  input wire logic sda_oe_n_i,
  input wire logic data_out_i,
  // Resolved lines
  output logic scl_o,
  output logic sda_o
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  logic [7:0] rx = 8'h00;

  // Lines released by the device follow the master's own drive levels
  assign scl_o = scl_oe_n_i ? scl_drv : scl_pin_i;
  assign sda_o = sda_oe_n_i ? sda_drv : sda_pin_i;

  task automatic set_lines(input logic c, input logic d);
    scl_drv = c;
    sda_drv = d;
  endtask : set_lines

  // One 200 ns clock period per bit, data set half a period ahead
  // Mode 1 idles high, so its first edge of each bit is the falling one
  task automatic spi_byte(input logic [7:0] tx, input logic mode1);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = tx[i];
      #100;
      scl_drv = !mode1;
      rx = {rx[6:0], data_out_i};
      #100;
      scl_drv = mode1;
    end
  endtask : spi_byte

  task automatic i2c_start();
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    #500;
    sda_drv = 1'b0;
    #500;
    scl_drv = 1'b0;
    #500;
  endtask : i2c_start

  // Release the clock and wait a bounded time for it to rise
  task automatic i2c_bit(input logic b, output logic ok);
    sda_drv = b;
    #100;
    scl_drv = 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      #100;
      ok = scl_o;
    end
    scl_drv = 1'b0;
  endtask : i2c_bit
endmodule : far_master
`default_nettype wire

// ### dv/tb.sv
// Self-checking testbench for the universal serial shift unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ussu_pkg::*;
  logic clock_i, nrst_i;
  wire_mode_e wm;
  logic ext_sel, edge_sel, p_lvl, p_cdir, p_ddir;
  logic sw_stb, tog_stb, tmr, d_wr, c_wr, ovf_clr, st_clr;
  logic [7:0] wdata;
  logic [3:0] cwdata;
  logic scl, sda, scl_po, scl_oe_n, dout, dout_oe_n, sda_po, sda_oe_n;
  logic [7:0] sdata;
  logic [3:0] cnt;
  logic ovf, stf, ovf_wake, st_wake, ok, okall;
  int fails, n_compared;

  universal_serial_shift_unit u_universal_serial_shift_unit (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .serial_clock_pin_i(scl), .serial_clock_pin_o(scl_po),
    .serial_clock_pin_oe_n_o(scl_oe_n), .serial_data_in_pin_i(sda),
    .data_out_pin_o(dout), .data_out_pin_oe_n_o(dout_oe_n),
    .sda_pin_o(sda_po), .sda_pin_oe_n_o(sda_oe_n), .wire_mode_i(wm),
    .external_clock_select_i(ext_sel), .clock_edge_select_i(edge_sel),
    .port_clock_level_i(p_lvl), .port_clock_dir_i(p_cdir), .port_data_dir_i(p_ddir),
    .software_clock_strobe_i(sw_stb), .clock_toggle_strobe_i(tog_stb),
    .timer_match_i(tmr), .data_wr_i(d_wr), .data_wdata_i(wdata), .count_wr_i(c_wr),
    .count_wdata_i(cwdata), .overflow_clear_i(ovf_clr), .start_clear_i(st_clr),
    .shift_data_o(sdata), .count_o(cnt), .counter_overflow_flag_o(ovf),
    .start_condition_flag_o(stf), .overflow_wake_o(ovf_wake), .start_wake_o(st_wake));

  far_master u_far_master (
    .scl_pin_i(scl_po), .scl_oe_n_i(scl_oe_n), .sda_pin_i(sda_po),
    .sda_oe_n_i(sda_oe_n), .data_out_i(dout), .scl_o(scl), .sda_o(sda));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(3);
  endtask : pulse

  // Loads data and counter and clears both flags in one cycle
  task automatic load(input logic [7:0] d, input logic [3:0] c);
    {wdata, cwdata} = {d, c};
    {d_wr, c_wr, ovf_clr, st_clr} = 4'hf;
    tick(1);
    {d_wr, c_wr, ovf_clr, st_clr} = 4'h0;
    tick(3);
  endtask : load

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_spi();
    wm = WM_THREE;
    {ext_sel, edge_sel, p_ddir} = 3'b101;
    u_far_master.set_lines(1'b0, 1'b1);
    tick(10);
    load(8'h3c, CNT_RST);
    check({7'h0, dout_oe_n}, 8'h00);
    u_far_master.spi_byte(8'ha5, 1'b0);
    tick(20);
    check(sdata, 8'ha5);
    check(u_far_master.rx, 8'h3c);
    check({2'h0, ovf, ovf_wake, cnt}, 8'h30);
    edge_sel = 1'b1;
    u_far_master.set_lines(1'b1, 1'b1);
    tick(10);
    load(8'h81, CNT_RST);
    u_far_master.spi_byte(8'h5a, 1'b1);
    tick(20);
    check({sdata[7:0]}, 8'h5a);
    check(u_far_master.rx, 8'h81);
    check({3'h0, ovf, cnt}, 8'h10);
  endtask : test_spi

  task automatic test_strobes();
    {ext_sel, edge_sel, p_cdir, p_lvl} = 4'h0;
    u_far_master.set_lines(1'b1, 1'b1);
    tick(10);
    load(8'h81, CNT_RST);
    u_far_master.set_lines(1'b1, 1'b0);
    tick(10);
    check({7'h0, stf}, 8'h00);
    pulse(sw_stb);
    check(sdata, 8'h02);
    check({4'h0, cnt}, 8'h01);
    edge_sel = 1'b1;
    u_far_master.set_lines(1'b1, 1'b1);
    tick(4);
    pulse(tmr);
    check(sdata, 8'h05);
    check({4'h0, cnt}, 8'h02);
    edge_sel = 1'b0;
    load(8'h00, CNT_LAST);
    pulse(sw_stb);
    check({2'h0, ovf, ovf_wake, cnt}, 8'h30);
    pulse(ovf_clr);
    check({6'h0, ovf, ovf_wake}, 8'h00);
    p_cdir = 1'b1;
    tick(3);
    check({6'h0, scl_oe_n, scl_po}, 8'h00);
    pulse(tog_stb);
    check({7'h0, scl_po}, 8'h01);
    p_lvl = 1'b1;
    tick(3);
    check({7'h0, scl_po}, 8'h00);
  endtask : test_strobes

  task automatic test_two_wire();
    wm = WM_TWO_HOLD;
    {ext_sel, edge_sel, p_cdir, p_ddir, p_lvl} = 5'b10000;
    u_far_master.set_lines(1'b1, 1'b1);
    tick(20);
    load(8'h00, CNT_RST);
    u_far_master.i2c_start();
    check({6'h0, stf, st_wake}, 8'h03);
    check({7'h0, scl_oe_n}, 8'h00);
    u_far_master.i2c_bit(1'b1, ok);
    check({7'h0, ok}, 8'h00);
    load(8'h00, CNT_RST);
    check({6'h0, stf, scl_oe_n}, 8'h01);
    okall = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      u_far_master.i2c_bit(1'(8'ha6 >> i), ok);
      okall &= ok;
    end
    tick(8);
    check({7'h0, okall}, 8'h01);
    check(sdata, 8'ha6);
    check({2'h0, ovf, stf, cnt}, 8'h20);
    check({7'h0, scl_oe_n}, 8'h00);
    p_ddir = 1'b1;
    load(8'h00, CNT_ACK_PRESET);
    check({6'h0, sda, scl_oe_n}, 8'h01);
    check({6'h0, sda_po, sda_oe_n}, 8'h00);
    u_far_master.i2c_bit(1'b1, ok);
    tick(8);
    check({3'h0, ovf, cnt}, 8'h10);
    check({7'h0, scl_oe_n}, 8'h00);
    load(8'h80, CNT_ACK_PRESET);
    check({7'h0, sda}, 8'h01);
    // Plain two-wire mode keeps the start hold only, not the overflow hold
    wm = WM_TWO;
    load(8'h80, CNT_LAST);
    u_far_master.i2c_bit(1'b1, ok);
    tick(8);
    check({5'h0, ok, ovf, scl_oe_n}, 8'h07);
  endtask : test_two_wire

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {fails, n_compared} = '0;
    wm = WM_OFF;
    {nrst_i, ext_sel, edge_sel, p_lvl, p_cdir, p_ddir} = '0;
    {sw_stb, tog_stb, tmr, d_wr, c_wr, ovf_clr, st_clr, wdata, cwdata} = '0;
    tick(20);
    nrst_i = 1'b1;
    tick(1);
    check(sdata, DATA_RST);
    check({2'h0, ovf, stf, cnt}, 8'h00);
    check({5'h0, scl_oe_n, dout_oe_n, sda_oe_n}, 8'h07);
    test_spi();
    test_strobes();
    test_two_wire();
    finish_test();
  end

  initial begin
    #400000;
    fails++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
